//--- core/dcf_fifo.sv
// Added by the designer: the address map and register access over APB.
`timescale 1ns/100ps

module dcf_fifo #(
   parameter int DEPTH = dcf_pkg::DEPTH_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [dcf_pkg::APB_AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dcf_pkg::APB_DW-1:0] pwdata,
   output logic [dcf_pkg::APB_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic wr_clk,
   input wire logic write_en_n,
   input wire logic [dcf_pkg::DATA_W-1:0] data_in,
   input wire logic rd_clk,
   input wire logic read_en_n,
   output logic [dcf_pkg::DATA_W-1:0] data_out,
   output logic empty_n,
   output logic full_n,
   output logic almost_empty_n,
   output logic almost_full_n,
   output logic half_full_n,
   output logic read_cascade_out,
   input wire logic write_cascade_in,
   input wire logic read_cascade_in,
   input wire logic first_device_sel,
   input wire logic almost_flag_sync_sel
);

   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 1;

   generate
      if (DEPTH != 256 && DEPTH != 512 && DEPTH != 1024 && DEPTH != 4096) begin : g_bad_depth
         $error("dcf_fifo: DEPTH must be 256, 512, 1024 or 4096");
      end
   endgenerate

   function automatic logic rise(input logic now_lvl, input logic old_lvl);
      rise = now_lvl & ~old_lvl;
   endfunction : rise

   // pin synchroniser; data rides the same two stages so it lines up with the edge
   dcf_pkg::dcf_pins_s pins_raw;
   dcf_pkg::dcf_pins_s sync1_ff;
   dcf_pkg::dcf_pins_s sync2_ff;
   logic [3:0] old_ff;

   always_comb begin
      pins_raw = '{wr_clk: wr_clk, rd_clk: rd_clk, write_en_n: write_en_n,
                   read_en_n: read_en_n, write_cascade_in: write_cascade_in,
                   read_cascade_in: read_cascade_in, first_device_sel: first_device_sel,
                   almost_flag_sync_sel: almost_flag_sync_sel, data: data_in};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_ff <= dcf_pkg::PINS_RST;
         sync2_ff <= dcf_pkg::PINS_RST;
         old_ff <= 4'h0;
      end else begin
         sync1_ff <= pins_raw;
         sync2_ff <= sync1_ff;
         old_ff <= {sync2_ff.wr_clk, sync2_ff.rd_clk,
                    sync2_ff.write_cascade_in, sync2_ff.read_cascade_in};
      end
   end

   logic wr_ev;
   logic rd_ev;
   logic wci_ev;
   logic rci_ev;

   always_comb begin
      wr_ev = rise(sync2_ff.wr_clk, old_ff[3]);
      rd_ev = rise(sync2_ff.rd_clk, old_ff[2]);
      wci_ev = rise(sync2_ff.write_cascade_in, old_ff[1]);
      rci_ev = rise(sync2_ff.read_cascade_in, old_ff[0]);
   end

   dcf_pkg::dcf_flags_s flags_ff;
   dcf_pkg::dcf_flags_s nxt_flags;

   // storage and pointers
   logic [dcf_pkg::DATA_W-1:0] mem [DEPTH];
   logic [PW-1:0] wptr_ff;
   logic [PW-1:0] rptr_ff;
   logic [dcf_pkg::DATA_W-1:0] dout_ff;
   logic [PW-1:0] nxt_wptr;
   logic [PW-1:0] nxt_rptr;
   logic [dcf_pkg::DATA_W-1:0] nxt_dout;

   // control and cascade state
   logic casc_ff;
   logic [dcf_pkg::OFS_W-1:0] ae_ofs_ff;
   logic [dcf_pkg::OFS_W-1:0] af_ofs_ff;
   logic started_ff;
   logic wtok_ff;
   logic rtok_ff;
   logic wco_ff;
   logic rco_ff;
   logic nxt_started;
   logic nxt_wtok;
   logic nxt_rtok;
   logic nxt_wco;
   logic nxt_rco;

   logic [PW-1:0] count;
   logic [PW-1:0] cnt_after;
   logic [dcf_pkg::CNT_W-1:0] cnt_ext;
   logic is_full;
   logic is_empty;
   logic do_wr;
   logic do_rd;
   logic ae_now;
   logic af_now;

   always_comb begin
      count = wptr_ff - rptr_ff;
      is_full = count == PW'(DEPTH);
      is_empty = count == '0;
      // a device without the token stays idle in a cascade
      // gate on the flags too, so the port obeys what the pins showed at its edge
      do_wr = wr_ev & ~sync2_ff.write_en_n & ~is_full & flags_ff.full_n
              & (~casc_ff | wtok_ff);
      do_rd = rd_ev & ~sync2_ff.read_en_n & ~is_empty & flags_ff.empty_n
              & (~casc_ff | rtok_ff);
      cnt_after = count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
      cnt_ext = dcf_pkg::CNT_W'(cnt_after);
      ae_now = cnt_ext <= {1'b0, ae_ofs_ff};
      af_now = ({1'b0, cnt_ext} + {2'b00, af_ofs_ff}) >= (dcf_pkg::CNT_W + 1)'(DEPTH);
      nxt_wptr = wptr_ff + {{AW{1'b0}}, do_wr};
      nxt_rptr = rptr_ff + {{AW{1'b0}}, do_rd};
      nxt_dout = do_rd ? mem[rptr_ff[AW-1:0]] : dout_ff;
   end

   always_ff @(posedge pclk) begin
      if (do_wr) begin
         mem[wptr_ff[AW-1:0]] <= sync2_ff.data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wptr_ff <= '0;
         rptr_ff <= '0;
         dout_ff <= '0;
      end else begin
         wptr_ff <= nxt_wptr;
         rptr_ff <= nxt_rptr;
         dout_ff <= nxt_dout;
      end
   end

   // status flags; empty and full move only on the edge of their own port clock
   always_comb begin
      nxt_flags = flags_ff;
      if (rd_ev) begin
         nxt_flags.empty_n = cnt_after != '0;
      end
      if (wr_ev) begin
         nxt_flags.full_n = cnt_after != PW'(DEPTH);
      end
      if (sync2_ff.almost_flag_sync_sel) begin
         nxt_flags.almost_empty_n = ~ae_now;
         nxt_flags.almost_full_n = ~af_now;
      end else begin
         if (rd_ev) begin
            nxt_flags.almost_empty_n = ~ae_now;
         end
         if (wr_ev) begin
            nxt_flags.almost_full_n = ~af_now;
         end
      end
      // shared pin: cascade carries the write hand-off, else half-full
      if (casc_ff) begin
         nxt_flags.half_full_n = ~nxt_wco;
      end else begin
         nxt_flags.half_full_n = ~(cnt_after > PW'(DEPTH / 2));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_ff <= dcf_pkg::FLAGS_RST;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   // cascade tokens; strap read on the first clock after reset release, from the PINS_RST value still in sync2_ff
   always_comb begin
      nxt_started = 1'b1;
      nxt_wtok = wtok_ff;
      nxt_rtok = rtok_ff;
      nxt_wco = wco_ff;
      nxt_rco = rco_ff;
      if (!started_ff) begin
         nxt_wtok = ~sync2_ff.first_device_sel;
         nxt_rtok = ~sync2_ff.first_device_sel;
      end else begin
         if (wr_ev) begin
            nxt_wco = 1'b0;
         end
         if (rd_ev) begin
            nxt_rco = 1'b0;
         end
         // own fill ends the turn; the loop-back returns it later
         if (casc_ff && do_wr && cnt_after == PW'(DEPTH)) begin
            nxt_wtok = 1'b0;
            nxt_wco = 1'b1;
         end else if (wci_ev) begin
            nxt_wtok = 1'b1;
         end
         if (casc_ff && do_rd && cnt_after == '0) begin
            nxt_rtok = 1'b0;
            nxt_rco = 1'b1;
         end else if (rci_ev) begin
            nxt_rtok = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         started_ff <= 1'b0;
         wtok_ff <= 1'b0;
         rtok_ff <= 1'b0;
         wco_ff <= 1'b0;
         rco_ff <= 1'b0;
      end else begin
         started_ff <= nxt_started;
         wtok_ff <= nxt_wtok;
         rtok_ff <= nxt_rtok;
         wco_ff <= nxt_wco;
         rco_ff <= nxt_rco;
      end
   end

   // apb slave: one wait-free access phase, pready from a flop
   logic pready_ff;
   logic pslverr_ff;
   logic [dcf_pkg::APB_DW-1:0] prdata_ff;
   logic nxt_pready;
   logic nxt_pslverr;
   logic [dcf_pkg::APB_DW-1:0] nxt_prdata;
   logic nxt_casc;
   logic [dcf_pkg::OFS_W-1:0] nxt_ae_ofs;
   logic [dcf_pkg::OFS_W-1:0] nxt_af_ofs;
   logic wr_acc;
   logic mapped;

   always_comb begin
      nxt_pready = psel & ~penable;
      nxt_pslverr = 1'b0;
      nxt_prdata = '0;
      nxt_casc = casc_ff;
      nxt_ae_ofs = ae_ofs_ff;
      nxt_af_ofs = af_ofs_ff;
      wr_acc = psel & penable & pready_ff & pwrite;
      mapped = 1'b1;
      case (paddr)
         dcf_pkg::ADDR_CTRL: begin
            nxt_prdata[dcf_pkg::CTRL_CASCADE_BIT] = casc_ff;
         end
         dcf_pkg::ADDR_AE_OFS: begin
            nxt_prdata[dcf_pkg::OFS_W-1:0] = ae_ofs_ff;
         end
         dcf_pkg::ADDR_AF_OFS: begin
            nxt_prdata[dcf_pkg::OFS_W-1:0] = af_ofs_ff;
         end
         dcf_pkg::ADDR_STATUS: begin
            nxt_prdata[dcf_pkg::STAT_CNT_LSB +: dcf_pkg::CNT_W] = dcf_pkg::CNT_W'(count);
            nxt_prdata[dcf_pkg::STAT_FLAGS_LSB +: 5] = flags_ff;
            nxt_prdata[dcf_pkg::STAT_WTOK_BIT] = wtok_ff;
            nxt_prdata[dcf_pkg::STAT_RTOK_BIT] = rtok_ff;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
      if (!(psel & ~penable)) begin
         nxt_prdata = '0;
      end else begin
         nxt_pslverr = ~mapped;
      end
      if (wr_acc) begin
         case (paddr)
            dcf_pkg::ADDR_CTRL: nxt_casc = pwdata[dcf_pkg::CTRL_CASCADE_BIT];
            dcf_pkg::ADDR_AE_OFS: nxt_ae_ofs = pwdata[dcf_pkg::OFS_W-1:0];
            dcf_pkg::ADDR_AF_OFS: nxt_af_ofs = pwdata[dcf_pkg::OFS_W-1:0];
            default: nxt_casc = casc_ff;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= '0;
         casc_ff <= dcf_pkg::CASCADE_RST;
         ae_ofs_ff <= dcf_pkg::AE_OFS_RST;
         af_ofs_ff <= dcf_pkg::AF_OFS_RST;
      end else begin
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         prdata_ff <= nxt_prdata;
         casc_ff <= nxt_casc;
         ae_ofs_ff <= nxt_ae_ofs;
         af_ofs_ff <= nxt_af_ofs;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign data_out = dout_ff;
   assign empty_n = flags_ff.empty_n;
   assign full_n = flags_ff.full_n;
   assign almost_empty_n = flags_ff.almost_empty_n;
   assign almost_full_n = flags_ff.almost_full_n;
   assign half_full_n = flags_ff.half_full_n;
   assign read_cascade_out = rco_ff;

endmodule : dcf_fifo

//--- core/dcf_pkg.sv
package dcf_pkg;

   // data path
   localparam int DATA_W = 18;
   localparam int DEPTH_DEF = 256;
   localparam int MAX_AW = 12;
   localparam int CNT_W = MAX_AW + 1;

   // apb register map
   localparam int APB_AW = 8;
   localparam int APB_DW = 32;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_AE_OFS = 8'h04;
   localparam logic [7:0] ADDR_AF_OFS = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;

   // field layout
   localparam int OFS_W = 12;
   localparam int CTRL_CASCADE_BIT = 0;
   localparam int STAT_CNT_LSB = 0;
   localparam int STAT_FLAGS_LSB = 16;
   localparam int STAT_WTOK_BIT = 21;
   localparam int STAT_RTOK_BIT = 22;

   // reset values
   localparam logic [11:0] AE_OFS_RST = 12'h007;
   localparam logic [11:0] AF_OFS_RST = 12'h007;
   localparam logic CASCADE_RST = 1'b0;

   // link clock period in the bench, for reference only
   localparam int LINK_PERIOD_NS = 160;

   typedef struct packed {
      logic empty_n;
      logic almost_empty_n;
      logic half_full_n;
      logic almost_full_n;
      logic full_n;
   } dcf_flags_s;

   // empty and almost empty low, the rest high, as after a clean reset
   localparam dcf_flags_s FLAGS_RST = 5'h07;

   typedef struct packed {
      logic wr_clk;
      logic rd_clk;
      logic write_en_n;
      logic read_en_n;
      logic write_cascade_in;
      logic read_cascade_in;
      logic first_device_sel;
      logic almost_flag_sync_sel;
      logic [17:0] data;
   } dcf_pins_s;

   // cascade inputs idle low so no false token edge follows reset
   localparam dcf_pins_s PINS_RST = 26'h0c00000;

endpackage : dcf_pkg

//--- dv/dcf_checker.sv
`timescale 1ns/100ps
module dcf_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [dcf_pkg::APB_AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic wr_clk,
   input wire logic rd_clk,
   input wire logic [dcf_pkg::DATA_W-1:0] data_out,
   input wire logic empty_n,
   input wire logic full_n,
   input wire logic almost_empty_n,
   input wire logic almost_full_n,
   input wire logic half_full_n,
   input wire logic almost_flag_sync_sel
);
   logic [1:0] rs_ff;
   logic [1:0] ws_ff;
   logic [3:0] ra_ff;
   logic [3:0] wa_ff;
   // ages saturate so a quiet port cannot wrap back into the window
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rs_ff <= 2'h0;
         ws_ff <= 2'h0;
         ra_ff <= 4'hf;
         wa_ff <= 4'hf;
      end else begin
         rs_ff <= {rs_ff[0], rd_clk};
         ws_ff <= {ws_ff[0], wr_clk};
         ra_ff <= (rs_ff[0] & ~rs_ff[1]) ? 4'h0 : ra_ff + {3'h0, ra_ff != 4'hf};
         wa_ff <= (ws_ff[0] & ~ws_ff[1]) ? 4'h0 : wa_ff + {3'h0, wa_ff != 4'hf};
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   AST_EMPTY_RD_ONLY: assert property ($changed(empty_n) |-> ra_ff <= 4'h6)
      else $error("empty flag moved away from a read clock rise");
   AST_FULL_WR_ONLY: assert property ($changed(full_n) |-> wa_ff <= 4'h6)
      else $error("full flag moved away from a write clock rise");
   AST_EMPTY_STEADY: assert property ($changed(empty_n) |=> $stable(empty_n) [*4])
      else $error("empty flag glitched");
   AST_FULL_STEADY: assert property ($changed(full_n) |=> $stable(full_n) [*4])
      else $error("full flag glitched");
   AST_DOUT_ON_READ: assert property ($changed(data_out) |-> ra_ff <= 4'h6 && $past(empty_n))
      else $error("read data moved without a read");
   AST_AE_SYNC: assert property (!almost_flag_sync_sel && $changed(almost_empty_n) |-> ra_ff <= 4'h6)
      else $error("clocked almost empty moved off the read clock");
   AST_FULL_FLAGS: assert property (!full_n |-> !almost_full_n && !half_full_n && empty_n)
      else $error("flags disagree with full");
   AST_APB_ANSWER: assert property (s_setup |=> s_answer)
      else $error("ready not a single cycle after setup");
   AST_APB_ERR: assert property (pready |-> pslverr == (paddr > 8'h0c))
      else $error("error response wrong for address");
endmodule : dcf_checker

bind dcf_fifo dcf_checker chk_i (.pclk, .presetn, .paddr, .psel, .penable, .pready, .pslverr,
   .wr_clk, .rd_clk, .data_out, .empty_n, .full_n, .almost_empty_n, .almost_full_n,
   .half_full_n, .almost_flag_sync_sel);

//--- dv/dcf_link_model.sv
`timescale 1ns/100ps
module dcf_link_model (
   input wire logic wr_on,
   input wire logic rd_on,
   output logic wr_clk,
   output logic rd_clk,
   output logic write_en_n,
   output logic read_en_n,
   output logic [17:0] data_in
);
   // port clocks run free; offsets keep their edges off the pclk edges
   initial begin
      write_en_n = 1'b1;
      read_en_n = 1'b1;
      data_in = 18'h00000;
      wr_clk = 1'b0;
      #7;
      forever #80 wr_clk = ~wr_clk;
   end
   initial begin
      rd_clk = 1'b0;
      #53;
      forever #80 rd_clk = ~rd_clk;
   end
   // data changes every cycle so a stale word is never mistaken for a fresh one
   always @(negedge wr_clk) begin
      write_en_n <= ~wr_on;
      data_in <= data_in + 18'h09e37;
   end
   always @(negedge rd_clk) begin
      read_en_n <= ~rd_on;
   end
endmodule : dcf_link_model

//--- dv/tb_dual_clock_fifo_with_flags.sv
`timescale 1ns/100ps
module tb_dual_clock_fifo_with_flags;
   localparam int DEPTH = 256;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, pend;
   logic wr_on, rd_on, sync_sel, wr_clk, rd_clk, write_en_n, read_en_n;
   logic empty_n, full_n, almost_empty_n, almost_full_n, half_full_n;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [17:0] data_in, data_out, last_q;
   logic [17:0] sb[$];
   logic [4:0] flags;
   int errors, tests_run, cyc;
   assign flags = {empty_n, almost_empty_n, half_full_n, almost_full_n, full_n};
   dcf_fifo #(.DEPTH(DEPTH)) dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .wr_clk, .write_en_n, .data_in, .rd_clk, .read_en_n,
      .data_out, .empty_n, .full_n, .almost_empty_n, .almost_full_n, .half_full_n,
      .read_cascade_out(), .write_cascade_in(1'b0), .read_cascade_in(1'b0),
      .first_device_sel(1'b0), .almost_flag_sync_sel(sync_sel));
   dcf_link_model link (.wr_on, .rd_on, .wr_clk, .rd_clk, .write_en_n, .read_en_n, .data_in);
   always #10 pclk = ~pclk;
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         errors++;
         give_verdict;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no limit of its own; if pready never rises only the bench timeout ends this wait
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so the next call never drives psel twice in one step
      @(posedge pclk);
   endtask : apb
   task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask : reg_chk
   // the word is only counted when the full flag allowed it at that rise
   always @(posedge wr_clk) if (!write_en_n && full_n === 1'b1) sb.push_back(data_in);
   // read data is judged at the next rise, long after it has settled
   always @(posedge rd_clk) begin
      if (pend) begin
         last_q = sb.pop_front();
         chk({14'h0, data_out}, {14'h0, last_q});
      end
      pend = !read_en_n && empty_n === 1'b1;
   end
   task automatic push(input int n);
      @(posedge wr_clk);
      @(posedge pclk);
      wr_on <= 1'b1;
      repeat (n) @(posedge wr_clk);
      @(posedge pclk);
      wr_on <= 1'b0;
   endtask : push
   task automatic settle;
      repeat (2) @(posedge rd_clk);
      repeat (2) @(posedge wr_clk);
      @(posedge pclk);
   endtask : settle
   task automatic drain;
      int n;
      n = 0;
      @(posedge pclk);
      rd_on <= 1'b1;
      while (empty_n !== 1'b0 && n < 9000) begin
         @(posedge pclk);
         n++;
      end
      repeat (3) @(posedge rd_clk);
      @(posedge pclk);
      rd_on <= 1'b0;
      chk(sb.size(), 0);
   endtask : drain
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      wr_on = 1'b0;
      rd_on = 1'b0;
      sync_sel = 1'b0;
      pend = 1'b0;
      errors = 0;
      tests_run = 0;
      cyc = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      reg_chk(dcf_pkg::ADDR_CTRL, 32'h0);
      reg_chk(dcf_pkg::ADDR_AE_OFS, 32'h7);
      reg_chk(dcf_pkg::ADDR_AF_OFS, 32'h7);
      reg_chk(8'h10, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk({27'h0, flags}, 32'h07);
      apb(1'b1, dcf_pkg::ADDR_AE_OFS, 32'h3);
      reg_chk(dcf_pkg::ADDR_AE_OFS, 32'h3);
      $display("test registers done");
      push(3);
      settle;
      chk({27'h0, flags}, 32'h17);
      push(1);
      settle;
      chk({27'h0, flags}, 32'h1f);
      $display("test threshold done");
      push(DEPTH);
      settle;
      chk({27'h0, flags}, 32'h18);
      chk(sb.size(), DEPTH);
      apb(1'b0, dcf_pkg::ADDR_STATUS, 32'h0);
      chk(q & 32'h00001fff, 32'h00000100);
      $display("test fill done");
      sync_sel <= 1'b1;
      drain;
      settle;
      chk({27'h0, flags}, 32'h07);
      chk({14'h0, data_out}, {14'h0, last_q});
      $display("test drain done");
      push(8);
      @(posedge pclk);
      rd_on <= 1'b1;
      push(60);
      drain;
      $display("test overlap done");
      give_verdict;
   end
endmodule : tb_dual_clock_fifo_with_flags
